// ==== design/cc_clkctrl.v ====
// Purpose: Clock controller registers, source switch and prescaler.
// Assumes: AXI4-Lite slave; oscillator ticks synchronous to clk.
// Notes: Index 0 fast RC, 1 low-power RC, 2 crystal, 3 external.
`timescale 1ns/10ps
`default_nettype none
`include "cc_clkctrl_map.vh"
module cc_clkctrl #(
    parameter [16:0] XO_WAIT_1K = 17'd1024,
    parameter [16:0] XO_WAIT_16K = 17'd16384,
    parameter [16:0] XO_WAIT_32K = 17'd32768,
    parameter [16:0] XO_WAIT_64K = 17'd65536
) (
    input wire clk,
    input wire nrst,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire freq_range_fuse,
    input wire [5:0] fuse_trim_low,
    input wire [5:0] fuse_trim_high,
    input wire [3:0] fuse_slope_low,
    input wire [3:0] fuse_slope_high,
    input wire trim_freeze_fuse,
    input wire [3:0] periph_osc_req,
    input wire [3:0] osc_tick,
    input wire [3:0] osc_analog_up,
    output wire [3:0] osc_run,
    output wire [3:0] osc_out_gate,
    output reg [1:0] main_src_active_q,
    output wire peripheral_clock_en,
    output wire [5:0] fast_rc_trim,
    output wire [3:0] fast_rc_temp_slope
);
    reg aw_have_q;
    reg [5:0] aw_idx_q;
    reg w_have_q;
    reg [7:0] w_data_q;
    reg w_lane_q;
    reg [1:0] main_source_sel_q;
    reg [4:0] div_ctrl_q;
    reg main_clock_freeze_bit_q;
    reg source_switch_pending_q;
    reg fast_stdby_q;
    reg ulp_stdby_q;
    reg [5:0] fast_rc_trim_q;
    reg [3:0] fast_rc_temp_slope_q;
    reg fuse_lock_q;
    reg [2:0] xo_ctrl_q;
    reg [1:0] crystal_startup_sel_q;
    reg [2:0] key_left_q;
    reg [3:0] osc_req;
    reg [3:0] osc_keep;
    reg [16:0] xo_limit;
    reg [7:0] rd_val;
    reg rd_ok;
    reg [16:0] gate_limit [0:3];
    wire do_write;
    wire unlocked;
    wire main_frozen;
    wire trim_frozen;
    wire xo_frozen;
    wire [5:0] ar_idx;
    wire [7:0] state_val;
    wire [3:0] skip_analog;
    wire freeze_refused;
    wire wr_ok;
    integer i;
    genvar g;

    function [5:0] word_idx;
        input [7:0] addr;
        begin
            word_idx = addr[7:2];
        end
    endfunction

    function is_mapped;
        input [5:0] idx;
        begin
            if (idx == `CC_IDX_SRC_CTRL) is_mapped = 1'b1;
            else if (idx == `CC_IDX_DIV_CTRL) is_mapped = 1'b1;
            else if (idx == `CC_IDX_FREEZE) is_mapped = 1'b1;
            else if (idx == `CC_IDX_STATE) is_mapped = 1'b1;
            else if (idx == `CC_IDX_FRC_CTRL) is_mapped = 1'b1;
            else if (idx == `CC_IDX_FRC_TRIM_A) is_mapped = 1'b1;
            else if (idx == `CC_IDX_FRC_TRIM_B) is_mapped = 1'b1;
            else if (idx == `CC_IDX_ULP_CTRL) is_mapped = 1'b1;
            else if (idx == `CC_IDX_XO_CTRL) is_mapped = 1'b1;
            else if (idx == `CC_IDX_KEY) is_mapped = 1'b1;
            else is_mapped = 1'b0;
        end
    endfunction

    // Write address and data are taken in either order.
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    assign ar_idx = word_idx(s_axi_araddr);

    assign unlocked = (key_left_q != 3'h0);
    assign main_frozen = main_clock_freeze_bit_q;
    assign trim_frozen = fuse_lock_q || (main_frozen &&
        main_src_active_q == `CC_SRC_FAST);
    assign xo_frozen = xo_ctrl_q[`CC_BIT_XO_EN] || osc_out_gate[2];
    assign freeze_refused = main_frozen && aw_idx_q == `CC_IDX_FREEZE;
    assign wr_ok = is_mapped(aw_idx_q) && !freeze_refused;

    assign state_val = {osc_out_gate[3], osc_out_gate[2],
        osc_out_gate[1], osc_out_gate[0], 3'h0,
        source_switch_pending_q};

    always @(posedge clk) begin
        if (!nrst) begin
            aw_have_q <= 1'b0;
            aw_idx_q <= 6'h00;
            w_have_q <= 1'b0;
            w_data_q <= 8'h00;
            w_lane_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_idx_q <= word_idx(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `CC_RESP_OKAY : `CC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register stores; every register except the key needs an open key window.
    always @(posedge clk) begin
        if (!nrst) begin
            main_source_sel_q <= `CC_SRC_FAST;
            div_ctrl_q <= `CC_RST_DIV_CTRL;
            main_clock_freeze_bit_q <= 1'b0;
            fast_stdby_q <= 1'b0;
            ulp_stdby_q <= 1'b0;
            xo_ctrl_q <= 3'h0;
            crystal_startup_sel_q <= 2'h0;
            key_left_q <= 3'h0;
            fuse_lock_q <= trim_freeze_fuse;
            fast_rc_trim_q <= freq_range_fuse ? fuse_trim_high : fuse_trim_low;
            fast_rc_temp_slope_q <= freq_range_fuse ?
                fuse_slope_high : fuse_slope_low;
        end else if (do_write && w_lane_q) begin
            if (aw_idx_q == `CC_IDX_KEY) begin
                key_left_q <= (w_data_q == `CC_KEY_VALUE) ? `CC_KEY_WRITES : 3'h0;
            end else begin
                if (unlocked) begin
                    key_left_q <= key_left_q - 3'h1;
                end
                if (!unlocked) begin
                    key_left_q <= 3'h0;
                end else if (aw_idx_q == `CC_IDX_SRC_CTRL) begin
                    if (!main_frozen) begin
                        main_source_sel_q <= w_data_q[1:0];
                    end
                end else if (aw_idx_q == `CC_IDX_DIV_CTRL) begin
                    if (!main_frozen) begin
                        div_ctrl_q <= w_data_q[4:0];
                    end
                end else if (aw_idx_q == `CC_IDX_FREEZE) begin
                    if (!main_frozen && w_data_q[`CC_BIT_FREEZE]) begin
                        main_clock_freeze_bit_q <= 1'b1;
                    end
                end else if (aw_idx_q == `CC_IDX_FRC_CTRL) begin
                    fast_stdby_q <= w_data_q[`CC_BIT_STDBY];
                end else if (aw_idx_q == `CC_IDX_FRC_TRIM_A) begin
                    if (!trim_frozen) begin
                        fast_rc_trim_q <= w_data_q[5:0];
                    end
                end else if (aw_idx_q == `CC_IDX_FRC_TRIM_B) begin
                    if (!trim_frozen) begin
                        fast_rc_temp_slope_q <= w_data_q[3:0];
                    end
                end else if (aw_idx_q == `CC_IDX_ULP_CTRL) begin
                    ulp_stdby_q <= w_data_q[`CC_BIT_STDBY];
                end else if (aw_idx_q == `CC_IDX_XO_CTRL) begin
                    xo_ctrl_q[1:0] <= w_data_q[1:0];
                    if (!xo_frozen) begin
                        xo_ctrl_q[`CC_BIT_XO_SEL] <= w_data_q[`CC_BIT_XO_SEL];
                        crystal_startup_sel_q <= w_data_q[5:4];
                    end
                end
            end
        end
    end

    // Old source stays active until the requested one is stable.
    always @(posedge clk) begin
        if (!nrst) begin
            main_src_active_q <= `CC_SRC_FAST;
            source_switch_pending_q <= 1'b0;
        end else if (main_source_sel_q != main_src_active_q) begin
            source_switch_pending_q <= 1'b1;
            if (osc_out_gate[main_source_sel_q]) begin
                main_src_active_q <= main_source_sel_q;
                source_switch_pending_q <= 1'b0;
            end
        end else begin
            source_switch_pending_q <= 1'b0;
        end
    end

    always @* begin
        for (i = 0; i < 4; i = i + 1) begin
            osc_req[i] = periph_osc_req[i] || main_source_sel_q == i[1:0] ||
                main_src_active_q == i[1:0];
        end
        osc_req[2] = osc_req[2] && xo_ctrl_q[`CC_BIT_XO_EN];
        osc_keep = {1'b0, xo_ctrl_q[`CC_BIT_XO_EN] && xo_ctrl_q[`CC_BIT_STDBY],
            ulp_stdby_q, fast_stdby_q};
        case (crystal_startup_sel_q)
            2'h0: xo_limit = XO_WAIT_1K;
            2'h1: xo_limit = XO_WAIT_16K;
            2'h2: xo_limit = XO_WAIT_32K;
            default: xo_limit = XO_WAIT_64K;
        endcase
        if (xo_ctrl_q[`CC_BIT_XO_SEL]) begin
            xo_limit = `CC_EXT_START_CYCLES;
        end
        gate_limit[0] = `CC_RC_GATE_CYCLES;
        gate_limit[1] = `CC_RC_GATE_CYCLES;
        gate_limit[2] = xo_limit;
        gate_limit[3] = `CC_EXT_START_CYCLES;
    end

    assign skip_analog = {1'b1, 1'b0, ulp_stdby_q, fast_stdby_q};

    generate
        for (g = 0; g < 4; g = g + 1) begin : osc
            cc_osc_gate u_gate (
                .clk(clk),
                .nrst(nrst),
                .req(osc_req[g]),
                .keep(osc_keep[g]),
                .osc_tick(osc_tick[g]),
                .analog_up(osc_analog_up[g]),
                .skip_analog(skip_analog[g]),
                .limit(gate_limit[g]),
                .run(osc_run[g]),
                .open_q(osc_out_gate[g])
            );
        end
    endgenerate

    cc_prescaler u_prescaler (
        .clk(clk),
        .nrst(nrst),
        .on(div_ctrl_q[`CC_BIT_PRESCALE_ON]),
        .sel(div_ctrl_q[4:1]),
        .tick_q(peripheral_clock_en)
    );

    assign fast_rc_trim = fast_rc_trim_q;
    assign fast_rc_temp_slope = fast_rc_temp_slope_q;

    always @* begin
        rd_ok = 1'b1;
        rd_val = 8'h00;
        if (ar_idx == `CC_IDX_SRC_CTRL) rd_val = {6'h00, main_source_sel_q};
        else if (ar_idx == `CC_IDX_DIV_CTRL) rd_val = {3'h0, div_ctrl_q};
        else if (ar_idx == `CC_IDX_FREEZE) begin
            rd_ok = !main_frozen;
            rd_val = main_frozen ? 8'h00 : 8'h00;
        end
        else if (ar_idx == `CC_IDX_STATE) rd_val = state_val;
        else if (ar_idx == `CC_IDX_FRC_CTRL) rd_val = {6'h00, fast_stdby_q, 1'b0};
        else if (ar_idx == `CC_IDX_FRC_TRIM_A) rd_val = {2'h0, fast_rc_trim_q};
        else if (ar_idx == `CC_IDX_FRC_TRIM_B) rd_val = {fuse_lock_q, 3'h0,
            fast_rc_temp_slope_q};
        else if (ar_idx == `CC_IDX_ULP_CTRL) rd_val = {6'h00, ulp_stdby_q, 1'b0};
        else if (ar_idx == `CC_IDX_XO_CTRL) rd_val = {2'h0, crystal_startup_sel_q,
            1'b0, xo_ctrl_q[2:0]};
        else if (ar_idx == `CC_IDX_KEY) rd_val = 8'h00;
        else rd_ok = 1'b0;
    end

    always @(posedge clk) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_val};
            s_axi_rresp <= rd_ok ? `CC_RESP_OKAY : `CC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // cc_clkctrl
`default_nettype wire

// ==== design/cc_clkctrl_map.vh ====
// Purpose: Register map and constants of the clock controller.
// Assumes: Included by the top design module and the testbench files.
// Notes: Byte address of a register is four times its index.
`ifndef CC_CLKCTRL_MAP_VH
`define CC_CLKCTRL_MAP_VH
`define CC_IDX_SRC_CTRL 6'h00
`define CC_IDX_DIV_CTRL 6'h01
`define CC_IDX_FREEZE 6'h02
`define CC_IDX_STATE 6'h03
`define CC_IDX_FRC_CTRL 6'h10
`define CC_IDX_FRC_TRIM_A 6'h11
`define CC_IDX_FRC_TRIM_B 6'h12
`define CC_IDX_ULP_CTRL 6'h18
`define CC_IDX_XO_CTRL 6'h1c
`define CC_IDX_KEY 6'h20
`define CC_KEY_VALUE 8'hd8
`define CC_KEY_WRITES 3'h4
`define CC_RST_DIV_CTRL 5'h11
`define CC_BIT_PRESCALE_ON 0
`define CC_BIT_FREEZE 0
`define CC_BIT_STDBY 1
`define CC_BIT_XO_EN 0
`define CC_BIT_XO_SEL 2
`define CC_BIT_FUSE_LOCK 7
`define CC_BIT_EXT_STARTED 7
`define CC_BIT_SWITCH 0
`define CC_SRC_FAST 2'h0
`define CC_SRC_ULP 2'h1
`define CC_SRC_XTAL 2'h2
`define CC_SRC_EXT 2'h3
`define CC_RC_GATE_CYCLES 17'h00004
`define CC_EXT_START_CYCLES 17'h00002
`define CC_RESP_OKAY 2'h0
`define CC_RESP_SLVERR 2'h2
`endif

// ==== design/cc_osc_gate.v ====
// Purpose: Start-up counter and output gate of one oscillator.
// Assumes: Oscillator ticks arrive as one-cycle pulses on clk.
// Notes: Gate and count clear whenever the request drops.
`timescale 1ns/10ps
`default_nettype none
module cc_osc_gate (
    input wire clk,
    input wire nrst,
    input wire req,
    input wire keep,
    input wire osc_tick,
    input wire analog_up,
    input wire skip_analog,
    input wire [16:0] limit,
    output wire run,
    output reg open_q
);
    reg [16:0] cnt_q;
    wire [16:0] cnt_inc;

    assign run = req | keep;
    assign cnt_inc = cnt_q + 17'h00001;

    always @(posedge clk) begin
        if (!nrst) begin
            cnt_q <= 17'h00000;
            open_q <= 1'b0;
        end else if (!req) begin
            cnt_q <= 17'h00000;
            open_q <= 1'b0;
        end else if (!open_q && osc_tick && (analog_up || skip_analog)) begin
            cnt_q <= cnt_inc;
            open_q <= (cnt_inc >= limit);
        end
    end
endmodule // cc_osc_gate
`default_nettype wire

// ==== design/cc_prescaler.v ====
// Purpose: Divides the main clock into a peripheral clock enable.
// Assumes: One clock, synchronous active-low reset.
// Notes: Reserved codes divide by two.
`timescale 1ns/10ps
`default_nettype none
module cc_prescaler (
    input wire clk,
    input wire nrst,
    input wire on,
    input wire [3:0] sel,
    output reg tick_q
);
    reg [6:0] cnt_q;
    wire [6:0] last;

    function [6:0] ratio;
        input [3:0] code;
        begin
            case (code)
                4'h0: ratio = 7'h02;
                4'h1: ratio = 7'h04;
                4'h2: ratio = 7'h08;
                4'h3: ratio = 7'h10;
                4'h4: ratio = 7'h20;
                4'h5: ratio = 7'h40;
                4'h8: ratio = 7'h06;
                4'h9: ratio = 7'h0a;
                4'ha: ratio = 7'h0c;
                4'hb: ratio = 7'h18;
                4'hc: ratio = 7'h30;
                default: ratio = 7'h02;
            endcase
        end
    endfunction

    assign last = ratio(sel) - 7'h01;

    always @(posedge clk) begin
        if (!nrst) begin
            cnt_q <= 7'h00;
            tick_q <= 1'b0;
        end else if (!on) begin
            cnt_q <= 7'h00;
            tick_q <= 1'b1;
        end else if (cnt_q >= last) begin
            cnt_q <= 7'h00;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 7'h01;
            tick_q <= 1'b0;
        end
    end
endmodule // cc_prescaler
`default_nettype wire

// ==== tb/cc_clkctrl_assertions.sv ====
// Purpose: Port-level checker for the clock controller.
// Assumes: Bound to cc_clkctrl; one clock, synchronous active-low reset.
// Notes: Sees only the top module's ports.
`timescale 1ns/10ps
`default_nettype none
`include "cc_clkctrl_map.vh"
module cc_clkctrl_assertions (
    input wire logic clk,
    input wire logic nrst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] osc_tick,
    input wire logic [3:0] osc_run,
    input wire logic [3:0] osc_out_gate,
    input wire logic [1:0] main_src_active_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before it was accepted");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before it was accepted");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write got no response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read got no response");
    a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == `CC_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("refused read returned data");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_gate_needs_run: assert property ((osc_out_gate & ~$past(osc_run)) == 4'h0)
        else $error("output gate open on an oscillator that is not running");
    a_gate_on_tick: assert property ($rose(osc_out_gate[1]) |-> $past(osc_tick[1]))
        else $error("low-power gate opened without an oscillator tick");
    a_switch_stable: assert property ($changed(main_src_active_q) |-> osc_out_gate[main_src_active_q])
        else $error("main clock moved to a source that is not stable");
endmodule // cc_clkctrl_assertions

bind cc_clkctrl cc_clkctrl_assertions u_chk (.*);
`default_nettype wire

// ==== tb/cc_clkctrl_tb_top.sv ====
// Purpose: Self-checking testbench of the clock controller.
// Assumes: Oscillator ticks made here as alternate-cycle pulses.
// Notes: Small crystal waits keep the run short.
`timescale 1ns/10ps
`default_nettype none
`include "cc_clkctrl_map.vh"
module cc_clkctrl_tb_top;
    localparam logic [5:0] TRIM_LO = 6'h15, TRIM_HI = 6'h2c;
    localparam logic [3:0] SLOPE_LO = 4'h3, SLOPE_HI = 4'hc;
    logic clk = 1'b0, nrst = 1'b0;
    logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
    logic [31:0] w_data = 32'h0;
    logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
    logic f_range = 1'b1, f_freeze = 1'b1;
    logic [3:0] req = 4'h0, tick = 4'h0, aup = 4'hf, tmask = 4'hf;
    wire logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, pclk_en;
    wire logic [1:0] b_resp, r_resp, act;
    wire logic [31:0] r_data;
    wire logic [3:0] run, gate, slope;
    wire logic [5:0] trim;
    int err_total = 0, n_tests = 0;

    cc_clkctrl #(.XO_WAIT_1K(17'd8), .XO_WAIT_16K(17'd16), .XO_WAIT_32K(17'd24),
        .XO_WAIT_64K(17'd32)) dut (.clk(clk), .nrst(nrst),
        .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
        .s_axi_wdata(w_data), .s_axi_wstrb(4'h1), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
        .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
        .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
        .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
        .freq_range_fuse(f_range), .fuse_trim_low(TRIM_LO), .fuse_trim_high(TRIM_HI),
        .fuse_slope_low(SLOPE_LO), .fuse_slope_high(SLOPE_HI), .trim_freeze_fuse(f_freeze),
        .periph_osc_req(req), .osc_tick(tick), .osc_analog_up(aup), .osc_run(run),
        .osc_out_gate(gate), .main_src_active_q(act), .peripheral_clock_en(pclk_en),
        .fast_rc_trim(trim), .fast_rc_temp_slope(slope));

    always #25 clk = ~clk;
    always @(posedge clk) tick <= ~tick & tmask;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge clk);
        aw_addr <= {idx, 2'b00};
        w_data <= {24'h0, d};
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        forever begin
            @(negedge clk);
            ta = aw_v && aw_rdy;
            tw = w_v && w_rdy;
            tb = b_v;
            r = b_resp;
            @(posedge clk);
            if (ta) aw_v <= 1'b0;
            if (tw) w_v <= 1'b0;
            if (tb) begin
                b_r <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge clk);
        ar_addr <= {idx, 2'b00};
        ar_v <= 1'b1;
        r_r <= 1'b1;
        forever begin
            @(negedge clk);
            ta = ar_v && ar_rdy;
            tr = r_v;
            d = r_data;
            r = r_resp;
            @(posedge clk);
            if (ta) ar_v <= 1'b0;
            if (tr) begin
                r_r <= 1'b0;
                break;
            end
        end
    endtask

    task automatic kwr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] r);
        wr(`CC_IDX_KEY, `CC_KEY_VALUE, r);
        wr(idx, d, r);
    endtask

    task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        check(d, exp);
        check(r, `CC_RESP_OKAY);
    endtask

    task automatic period(output int p);
        p = 0;
        do @(negedge clk); while (!pclk_en);
        do begin
            @(negedge clk);
            p++;
        end while (!pclk_en);
    endtask

    task automatic t_reset;
        logic [1:0] r;
        logic [31:0] d;
        int p;
        wr(`CC_IDX_DIV_CTRL, 8'h00, r);
        check(r, `CC_RESP_OKAY);
        rchk(`CC_IDX_DIV_CTRL, 32'h11);
        rchk(`CC_IDX_SRC_CTRL, 32'h0);
        rchk(`CC_IDX_FREEZE, 32'h0);
        rchk(`CC_IDX_FRC_CTRL, 32'h0);
        rchk(`CC_IDX_ULP_CTRL, 32'h0);
        rchk(`CC_IDX_XO_CTRL, 32'h0);
        rchk(`CC_IDX_FRC_TRIM_A, TRIM_HI);
        rchk(`CC_IDX_FRC_TRIM_B, {24'h0, 4'h8, SLOPE_HI});
        check(slope, SLOPE_HI);
        rchk(`CC_IDX_STATE, 32'h10);
        rd(6'h05, d, r);
        check(r, `CC_RESP_SLVERR);
        kwr(`CC_IDX_FRC_TRIM_A, 8'h2a, r);
        rchk(`CC_IDX_FRC_TRIM_A, TRIM_HI);
        period(p);
        check(p, 6);
    endtask

    task automatic t_divider;
        int ratio[13] = '{2, 4, 8, 16, 32, 64, 2, 2, 6, 10, 12, 24, 48};
        logic [1:0] r;
        int p;
        for (int c = 0; c < 13; c++) begin
            kwr(`CC_IDX_DIV_CTRL, {3'h0, c[3:0], 1'b1}, r);
            period(p);
            period(p);
            check(p, ratio[c]);
        end
        kwr(`CC_IDX_DIV_CTRL, 8'h18, r);
        period(p);
        period(p);
        check(p, 1);
        rchk(`CC_IDX_DIV_CTRL, 32'h18);
        kwr(`CC_IDX_DIV_CTRL, 8'h19, r);
    endtask

    task automatic t_standby;
        logic [1:0] r;
        int n;
        kwr(`CC_IDX_ULP_CTRL, 8'h02, r);
        repeat (4) @(posedge clk);
        check(run[1], 1);
        check(gate[1], 0);
        rchk(`CC_IDX_STATE, 32'h10);
        @(posedge clk);
        req[1] <= 1'b1;
        n = 0;
        forever begin
            @(negedge clk);
            if (gate[1]) break;
            if (tick[1]) n++;
        end
        check(n, 4);
        rchk(`CC_IDX_STATE, 32'h30);
    endtask

    task automatic t_switch;
        logic [1:0] r;
        @(posedge clk);
        tmask[3] <= 1'b0;
        kwr(`CC_IDX_SRC_CTRL, 8'h03, r);
        rchk(`CC_IDX_STATE, 32'h31);
        check(act, 2'h0);
        @(posedge clk);
        tmask[3] <= 1'b1;
        repeat (20) @(posedge clk);
        rchk(`CC_IDX_STATE, 32'ha0);
        check(act, `CC_SRC_EXT);
        @(posedge clk);
        req[1] <= 1'b0;
        repeat (4) @(posedge clk);
        check(run[1], 1);
        rchk(`CC_IDX_STATE, 32'h80);
    endtask

    task automatic t_freeze;
        logic [1:0] r;
        logic [31:0] d;
        kwr(`CC_IDX_FREEZE, 8'h01, r);
        check(r, `CC_RESP_OKAY);
        kwr(`CC_IDX_DIV_CTRL, 8'h03, r);
        check(r, `CC_RESP_OKAY);
        rchk(`CC_IDX_DIV_CTRL, 32'h19);
        kwr(`CC_IDX_SRC_CTRL, 8'h00, r);
        rchk(`CC_IDX_SRC_CTRL, 32'h03);
        rd(`CC_IDX_FREEZE, d, r);
        check(r, `CC_RESP_SLVERR);
        check(d, 32'h0);
        kwr(`CC_IDX_FREEZE, 8'h01, r);
        check(r, `CC_RESP_SLVERR);
    endtask

    task automatic t_rereset;
        logic [1:0] r;
        @(posedge clk);
        nrst <= 1'b0;
        f_range <= 1'b0;
        f_freeze <= 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rchk(`CC_IDX_FREEZE, 32'h0);
        rchk(`CC_IDX_FRC_TRIM_A, TRIM_LO);
        rchk(`CC_IDX_FRC_TRIM_B, SLOPE_LO);
        kwr(`CC_IDX_FRC_TRIM_A, 8'h2a, r);
        rchk(`CC_IDX_FRC_TRIM_A, 32'h2a);
        check(trim, 6'h2a);
    endtask

    task automatic t_crystal;
        logic [1:0] r;
        int n;
        kwr(`CC_IDX_XO_CTRL, 8'h20, r);
        kwr(`CC_IDX_XO_CTRL, 8'h21, r);
        @(posedge clk);
        req[2] <= 1'b1;
        n = 0;
        forever begin
            @(negedge clk);
            if (gate[2]) break;
            if (tick[2]) n++;
        end
        check(n, 24);
        rchk(`CC_IDX_STATE, 32'h50);
        kwr(`CC_IDX_XO_CTRL, 8'h35, r);
        rchk(`CC_IDX_XO_CTRL, 32'h21);
        @(posedge clk);
        req[2] <= 1'b0;
        kwr(`CC_IDX_XO_CTRL, 8'h01, r);
        kwr(`CC_IDX_XO_CTRL, 8'h35, r);
        rchk(`CC_IDX_XO_CTRL, 32'h21);
        kwr(`CC_IDX_XO_CTRL, 8'h00, r);
        rchk(`CC_IDX_STATE, 32'h10);
        kwr(`CC_IDX_XO_CTRL, 8'h34, r);
        rchk(`CC_IDX_XO_CTRL, 32'h34);
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_reset;
        t_divider;
        t_standby;
        t_switch;
        t_freeze;
        t_rereset;
        t_crystal;
        summarize;
    end

    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        summarize;
    end
endmodule // cc_clkctrl_tb_top
`default_nettype wire
